// *** src/rfp_pkg.sv ***
// Package for the receive filter, polarity and link-quality configuration bank.
// Assumes a single 20 MHz core clock shared by every user of these constants.
`default_nettype none
package rfp_pkg;
  localparam int CLK_HZ = 20000000;
  // Printed offsets are register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_RX_FILTER = 16'h04a0;
  localparam logic [15:0] IDX_MDI_POL = 16'h0553;
  localparam logic [15:0] IDX_LINK_QUAL = 16'h0560;
  localparam logic [15:0] IDX_FAIL_CNT = 16'h0561;
  localparam logic [15:0] IDX_IRQ_STAT = 16'h0800;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h0801;
  localparam logic [15:0] RST_RX_FILTER = 16'h1000;
  localparam logic [15:0] RST_MDI_POL = 16'h0000;
  localparam logic [15:0] RST_LINK_QUAL = 16'h07e4;
  localparam logic [15:0] WMASK_RX_FILTER = 16'hfffd;
  localparam logic [15:0] WMASK_MDI_POL = 16'hffff;
  localparam logic [15:0] WMASK_LINK_QUAL = 16'h3fff;
  localparam int BIT_BYTE_ORDER = 14;
  localparam int BIT_SFD_SEL = 13;
  localparam int BIT_EXT_RX = 7;
  localparam int BIT_POL_EN = 13;
  localparam int BIT_POL_VAL = 12;
  localparam int BIT_LINK_SRC = 11;
  localparam int BIT_FAIL_MASK = 5;
  localparam int BIT_HYST_SEL = 3;
  localparam int BIT_SQI_THR = 0;
  localparam logic [7:0] SFD_NORMAL = 8'hd5;
  localparam logic [7:0] SFD_SWAPPED = 8'h5d;
  localparam int HYST_US_0 = 2000;
  localparam int HYST_US_1 = 500;
  localparam int HYST_US_2 = 1000;
  localparam int HYST_US_3 = 4000;
  localparam int HYST_CYC_0 = HYST_US_0 * (CLK_HZ / 1000000);
  localparam int HYST_CYC_1 = HYST_US_1 * (CLK_HZ / 1000000);
  localparam int HYST_CYC_2 = HYST_US_2 * (CLK_HZ / 1000000);
  localparam int HYST_CYC_3 = HYST_US_3 * (CLK_HZ / 1000000);
  localparam int IRQ_BITS = 3;
  localparam int IRQ_FAIL = 0;
  localparam int IRQ_CR_UP = 1;
  localparam int IRQ_CR_DOWN = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// *** src/rfp_cfg_bank.sv ***
// Configuration bank: receive byte order, delimiter select, extended receive
// features, MDI polarity override and link-quality monitoring, over AXI4-Lite.
// All user-side inputs come from logic on core_clk, so none are synchronised.
//
// Functional notes
// - Two-bit byte-order field: none, bit reverse, nibble swap, reverse within nibbles.
// - Extended receive enable, reset zero, gates wake, CRC check and timestamp.
// - Override enable zero uses detected polarity; one uses forced polarity.
// - Override value zero normal, one inverted; only effective while enabled.
// - Receive filter register resets to 1000h; only reserved bit 12 set.
// - Link-quality register resets to 07E4h: six mask bits set, threshold 100b.
// - Two-bit link-up source picks standard, monitor, send-data or comm-ready.
// - Hysteresis code selects 2 ms, 500 us, 1 ms or 4 ms comm-ready timer.
// - Failure count increments when quality becomes worse than the threshold, if enabled.
// - Each mask bit enables counting of one failure scenario.
//
// Our own choice: register access over AXI4-Lite.
`default_nettype none
module rfp_cfg_bank
  import rfp_pkg::*;
#(
  parameter int HYST_0 = HYST_CYC_0,
  parameter int HYST_1 = HYST_CYC_1,
  parameter int HYST_2 = HYST_CYC_2,
  parameter int HYST_3 = HYST_CYC_3,
  parameter int FAIL_W = 10
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_byte_in_valid,
  output logic [7:0] rx_byte_out,
  output logic rx_byte_out_valid,
  output logic [7:0] sfd_pattern,
  input wire logic wake_in,
  input wire logic crc_check_in,
  input wire logic rx_ts_in,
  output logic wake_out,
  output logic crc_check_out,
  output logic rx_ts_out,
  input wire logic pol_detected_inv,
  output logic mdi_pol_inverted,
  input wire logic link_up_std,
  input wire logic link_monitor_ok,
  input wire logic send_data_state,
  input wire logic comm_ready_raw,
  output logic comm_ready,
  output logic link_status,
  input wire logic [2:0] sqi_value,
  input wire logic [4:0] fail_evt,
  output logic [FAIL_W-1:0] link_failures,
  output logic irq
);
  logic [15:0] rx_filter_r;
  logic [15:0] mdi_pol_r;
  logic [15:0] link_qual_r;
  logic [IRQ_BITS-1:0] irq_stat_r;
  logic [IRQ_BITS-1:0] irq_mask_r;
  logic aw_held_r;
  logic w_held_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write;
  logic [15:0] wr_idx;
  logic [15:0] rd_idx;
  logic [15:0] wr_half;
  logic [15:0] wr_lanes;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  logic [16:0] hyst_cnt_r;
  logic [16:0] hyst_lim;
  logic comm_ready_nxt;
  logic sqi_bad;
  logic sqi_bad_r;
  logic [5:0] fail_hits;
  logic fail_inc;
  logic cr_up;
  logic cr_down;

  // Write channel: address and data are latched independently, in either order.
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_idx = awaddr_r[17:2];
  assign rd_idx = s_axi_araddr[17:2];
  assign wr_half = wdata_r[15:0];
  assign wr_lanes = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign wr_hit = (awaddr_r[31:18] == 14'h0000) &&
    (wr_idx == IDX_RX_FILTER || wr_idx == IDX_MDI_POL || wr_idx == IDX_LINK_QUAL ||
     wr_idx == IDX_FAIL_CNT || wr_idx == IDX_IRQ_STAT || wr_idx == IDX_IRQ_MASK);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 32'h0000_0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read-only reserved bits are kept out by the write masks.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_filter_r <= RST_RX_FILTER;
      mdi_pol_r <= RST_MDI_POL;
      link_qual_r <= RST_LINK_QUAL;
      irq_mask_r <= '0;
    end else if (do_write && awaddr_r[31:18] == 14'h0000) begin
      if (wr_idx == IDX_RX_FILTER) begin
        rx_filter_r <= (rx_filter_r & ~(wr_lanes & WMASK_RX_FILTER)) |
          (wr_half & wr_lanes & WMASK_RX_FILTER);
      end
      if (wr_idx == IDX_MDI_POL) begin
        mdi_pol_r <= (mdi_pol_r & ~(wr_lanes & WMASK_MDI_POL)) |
          (wr_half & wr_lanes & WMASK_MDI_POL);
      end
      if (wr_idx == IDX_LINK_QUAL) begin
        link_qual_r <= (link_qual_r & ~(wr_lanes & WMASK_LINK_QUAL)) |
          (wr_half & wr_lanes & WMASK_LINK_QUAL);
      end
      if (wr_idx == IDX_IRQ_MASK && wstrb_r[0]) begin
        irq_mask_r <= wdata_r[IRQ_BITS-1:0];
      end
    end
  end

  // Sticky status: a new event in the clearing cycle wins over the clear.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_stat_r <= '0;
    end else begin
      if (do_write && awaddr_r[31:18] == 14'h0000 && wr_idx == IDX_IRQ_STAT && wstrb_r[0])
      begin
        irq_stat_r <= (irq_stat_r & ~wdata_r[IRQ_BITS-1:0]) | {cr_down, cr_up, fail_inc};
      end else begin
        irq_stat_r <= irq_stat_r | {cr_down, cr_up, fail_inc};
      end
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // Read channel: one cycle from address to data.
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = (s_axi_araddr[31:18] == 14'h0000);
    case (rd_idx)
      IDX_RX_FILTER: rd_word = {16'h0000, rx_filter_r};
      IDX_MDI_POL: rd_word = {16'h0000, mdi_pol_r};
      IDX_LINK_QUAL: rd_word = {16'h0000, link_qual_r};
      IDX_FAIL_CNT: rd_word[FAIL_W-1:0] = link_failures;
      IDX_IRQ_STAT: rd_word[IRQ_BITS-1:0] = irq_stat_r;
      IDX_IRQ_MASK: rd_word[IRQ_BITS-1:0] = irq_mask_r;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_hit ? rd_word : 32'h0000_0000;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Receive byte reordering toward the MAC.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_byte_out <= 8'h00;
      rx_byte_out_valid <= 1'b0;
    end else begin
      rx_byte_out_valid <= rx_byte_in_valid;
      if (rx_byte_in_valid) begin
        case (rx_filter_r[BIT_BYTE_ORDER +: 2])
          2'b00: rx_byte_out <= rx_byte_in;
          2'b01: rx_byte_out <= {<<{rx_byte_in}};
          2'b10: rx_byte_out <= {rx_byte_in[3:0], rx_byte_in[7:4]};
          default: rx_byte_out <= {rx_byte_in[4], rx_byte_in[5], rx_byte_in[6],
            rx_byte_in[7], rx_byte_in[0], rx_byte_in[1], rx_byte_in[2], rx_byte_in[3]};
        endcase
      end
    end
  end

  // Delimiter, feature gates, polarity and link status follow the registers.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sfd_pattern <= SFD_NORMAL;
      wake_out <= 1'b0;
      crc_check_out <= 1'b0;
      rx_ts_out <= 1'b0;
      mdi_pol_inverted <= 1'b0;
      link_status <= 1'b0;
    end else begin
      sfd_pattern <= rx_filter_r[BIT_SFD_SEL] ? SFD_SWAPPED : SFD_NORMAL;
      wake_out <= wake_in && rx_filter_r[BIT_EXT_RX];
      crc_check_out <= crc_check_in && rx_filter_r[BIT_EXT_RX];
      rx_ts_out <= rx_ts_in && rx_filter_r[BIT_EXT_RX];
      mdi_pol_inverted <= mdi_pol_r[BIT_POL_EN] ? mdi_pol_r[BIT_POL_VAL] :
        pol_detected_inv;
      case (link_qual_r[BIT_LINK_SRC +: 2])
        2'b00: link_status <= link_up_std;
        2'b01: link_status <= link_monitor_ok;
        2'b10: link_status <= send_data_state;
        default: link_status <= comm_ready;
      endcase
    end
  end

  // Comm-ready rises only after the raw signal has held for the hysteresis
  // time and drops at once, so a brief dropout never reports a good link.
  always_comb begin
    case (link_qual_r[BIT_HYST_SEL +: 2])
      2'b00: hyst_lim = 17'(HYST_0);
      2'b01: hyst_lim = 17'(HYST_1);
      2'b10: hyst_lim = 17'(HYST_2);
      default: hyst_lim = 17'(HYST_3);
    endcase
  end

  assign comm_ready_nxt = comm_ready_raw && (comm_ready || hyst_cnt_r + 17'h1 >= hyst_lim);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hyst_cnt_r <= 17'h0;
      comm_ready <= 1'b0;
    end else begin
      comm_ready <= comm_ready_nxt;
      if (!comm_ready_raw || comm_ready_nxt) begin
        hyst_cnt_r <= 17'h0;
      end else begin
        hyst_cnt_r <= hyst_cnt_r + 17'h1;
      end
    end
  end

  assign cr_up = comm_ready_nxt && !comm_ready;
  assign cr_down = !comm_ready_nxt && comm_ready;

  // Failure counting; quality above the threshold counts as worse.
  assign sqi_bad = sqi_value > link_qual_r[BIT_SQI_THR +: 3];
  assign fail_hits = {fail_evt, sqi_bad && !sqi_bad_r} &
    link_qual_r[BIT_FAIL_MASK +: 6];
  assign fail_inc = |fail_hits;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sqi_bad_r <= 1'b0;
      link_failures <= '0;
    end else begin
      sqi_bad_r <= sqi_bad;
      if (fail_inc && !(&link_failures)) begin
        link_failures <= link_failures + 1'b1;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_bad_rise;
    sqi_bad && !sqi_bad_r && link_qual_r[BIT_FAIL_MASK];
  endsequence

  a_byte_swap: assert property (rx_byte_in_valid && rx_filter_r[15:14] == 2'b10
    |=> rx_byte_out == {$past(rx_byte_in[3:0]), $past(rx_byte_in[7:4])})
    else $error("nibble swap wrong");
  a_sfd_select: assert property (##1 sfd_pattern ==
    ($past(rx_filter_r[BIT_SFD_SEL]) ? 8'h5d : 8'hd5))
    else $error("delimiter pattern wrong");
  a_ext_gate: assert property (!rx_filter_r[BIT_EXT_RX] |=> !wake_out && !crc_check_out
    && !rx_ts_out)
    else $error("extended feature not gated");
  a_pol_auto: assert property (!mdi_pol_r[BIT_POL_EN] |=>
    mdi_pol_inverted == $past(pol_detected_inv))
    else $error("auto polarity not followed");
  a_pol_force: assert property (mdi_pol_r[BIT_POL_EN] |=>
    mdi_pol_inverted == $past(mdi_pol_r[BIT_POL_VAL]))
    else $error("forced polarity not applied");
  a_reserved_ro: assert property (rx_filter_r[1] == 1'b0 && link_qual_r[15:14] == 2'b00)
    else $error("read-only reserved bit set");
  a_link_src: assert property (link_qual_r[12:11] == 2'b01 |=>
    link_status == $past(link_monitor_ok))
    else $error("link source mux wrong");
  a_hyst_short: assert property (comm_ready_raw [*3] ##0 link_qual_r[4:3] == 2'b01
    ##0 $stable(link_qual_r[4:3]) ##0 !comm_ready |->
    hyst_cnt_r != 17'h0 && hyst_cnt_r < 17'(HYST_1))
    else $error("hysteresis counter out of range");
  a_cr_drop: assert property (!comm_ready_raw |=> !comm_ready)
    else $error("comm ready not dropped");
  a_fail_count: assert property (s_bad_rise ##0 link_failures != '1 |=>
    link_failures == $past(link_failures) + 1'b1)
    else $error("failure not counted");
  a_fail_masked: assert property (link_qual_r[10:5] == 6'h00 |=>
    $stable(link_failures))
    else $error("masked failure counted");
endmodule
`default_nettype wire

// *** sim/rfp_rx_src.sv ***
// Far-side receive source model: offers one data byte for one cycle on request.
// Assumes the caller raises go for exactly one core_clk cycle per byte.
`default_nettype none
module rfp_rx_src (
  input wire logic core_clk,
  input wire logic go,
  input wire logic [7:0] byte_in,
  output logic [7:0] rx_byte = 8'h5a,
  output logic rx_valid = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Outside a valid cycle the data keeps changing, so logic that ignores the
  // strobe cannot pass by luck on a stale byte.
  always @(posedge core_clk) begin
    rx_valid <= go;
    rx_byte <= go ? byte_in : ~rx_byte;
  end
endmodule
`default_nettype wire

// *** sim/rfp_cfg_bank_tb.sv ***
// Self-checking bench for the configuration bank, driven over AXI4-Lite.
// Assumes short hysteresis parameters so the whole run stays small.
`default_nettype none
module rfp_cfg_bank_tb;
  import rfp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HY[4] = '{20, 5, 10, 40};
  logic core_clk = 0, rst = 1, go = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rd, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, arready, bvalid, rvalid, rx_v, rx_out_v;
  logic [1:0] bresp, rresp, rsp;
  logic [7:0] sbyte = 0, rx_b, rx_out, sfd;
  logic wk = 1, crc = 1, ts = 1, det = 0, wk_o, crc_o, ts_o, pol_o;
  logic std = 0, mon = 0, snd = 0, craw = 0, cr, lstat, irq;
  logic [2:0] sqi = 0;
  logic [4:0] fevt = 0;
  logic [9:0] lfail;
  int fails = 0, tests_run = 0, cyc = 0, n;

  always #25 core_clk = ~core_clk;

  rfp_rx_src SRC (.core_clk(core_clk), .go(go), .byte_in(sbyte), .rx_byte(rx_b),
    .rx_valid(rx_v));
  rfp_cfg_bank #(.HYST_0(HY[0]), .HYST_1(HY[1]), .HYST_2(HY[2]), .HYST_3(HY[3]),
    .FAIL_W(10)) DUT (
    .core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_byte_in(rx_b), .rx_byte_in_valid(rx_v), .rx_byte_out(rx_out),
    .rx_byte_out_valid(rx_out_v), .sfd_pattern(sfd), .wake_in(wk), .crc_check_in(crc),
    .rx_ts_in(ts), .wake_out(wk_o), .crc_check_out(crc_o), .rx_ts_out(ts_o),
    .pol_detected_inv(det), .mdi_pol_inverted(pol_o), .link_up_std(std),
    .link_monitor_ok(mon), .send_data_state(snd), .comm_ready_raw(craw),
    .comm_ready(cr), .link_status(lstat), .sqi_value(sqi), .fail_evt(fevt),
    .link_failures(lfail), .irq(irq));

  task summarize;
    if (fails == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Address and data are released separately, each at its own handshake.
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    rsp = bresp;
  endtask

  task rd32(input logic [31:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    rd = rdata;
    rsp = rresp;
  endtask

  task settle(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task pulse(input logic [4:0] e);
    @(posedge core_clk);
    fevt <= e;
    @(posedge core_clk);
    fevt <= 0;
  endtask

  function automatic logic [7:0] reord(input int c, input logic [7:0] b);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = b[7 - i];
    case (c)
      0: return b;
      1: return r;
      2: return {b[3:0], b[7:4]};
      default: return {r[3:0], r[7:4]};
    endcase
  endfunction

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 0;
    rd32(32'h1280);
    chk(rd, 32'h1000);
    rd32(32'h1580);
    chk(rd, 32'h07e4);
    rd32(32'h154c);
    chk(rd, 32'h0000);
    chk({wk_o, crc_o, ts_o}, 0);
    rd32(32'h1000);
    chk(rsp, RESP_SLVERR);
    chk(rd, 32'h0);
    wr(32'h1000, 32'hffff);
    chk(rsp, RESP_SLVERR);
    wr(32'h1280, 32'hffff);
    chk(rsp, RESP_OKAY);
    rd32(32'h1280);
    chk(rd, 32'hfffd);
    wr(32'h1580, 32'hffff);
    rd32(32'h1580);
    chk(rd, 32'h3fff);
    wr(32'h1580, 32'h07e4);
    for (int c = 0; c < 4; c++) begin
      wr(32'h1280, 32'h1000 | (c << 14) | ((c & 1) << 13) | ((c >> 1) << 7));
      @(posedge core_clk);
      go <= 1;
      sbyte <= 8'h2c ^ 8'(c);
      @(posedge core_clk);
      go <= 0;
      settle(1);
      chk({rx_out_v, rx_out}, {1'b1, reord(c, 8'h2c ^ 8'(c))});
      chk(sfd, (c & 1) ? SFD_SWAPPED : SFD_NORMAL);
      chk({wk_o, crc_o, ts_o}, (c >> 1) ? 3'h7 : 3'h0);
      settle(1);
      chk(rx_out_v, 0);
    end
    for (int i = 0; i < 8; i++) begin
      wr(32'h154c, (i >> 1) << 12);
      @(posedge core_clk);
      det <= i[0];
      settle(2);
      chk(pol_o, (i & 4) ? ((i >> 1) & 1) : (i & 1));
    end
    for (int c = 0; c < 4; c++) begin
      wr(32'h1580, 32'h07e4 | (c << 11));
      @(posedge core_clk);
      {snd, mon, std} <= (c < 3) ? ~3'(1 << c) : 3'h7;
      settle(2);
      chk(lstat, 0);
      @(posedge core_clk);
      {snd, mon, std} <= (c < 3) ? 3'(1 << c) : 3'h0;
      settle(2);
      chk(lstat, c < 3);
    end
    for (int c = 0; c < 4; c++) begin
      wr(32'h1580, 32'h1fe4 | (c << 3));
      @(posedge core_clk);
      craw <= 1;
      n = 0;
      do begin
        settle(1);
        n++;
      end while (!cr && n < 100);
      chk(n, HY[c]);
      @(posedge core_clk);
      craw <= 0;
      settle(1);
      chk(cr, 0);
      chk(lstat, 1);
    end
    rd32(32'h2000);
    chk(rd, 32'h6);
    chk(irq, 0);
    wr(32'h2004, 32'h6);
    settle(1);
    chk(irq, 1);
    wr(32'h2000, 32'h6);
    settle(1);
    chk(irq, 0);
    wr(32'h2004, 32'h1);
    wr(32'h1580, 32'h07e4);
    for (int i = 0; i < 5; i++) pulse(5'(1 << i));
    @(posedge core_clk);
    sqi <= 4;
    settle(3);
    chk(lfail, 5);
    @(posedge core_clk);
    sqi <= 5;
    settle(4);
    chk(lfail, 6);
    @(posedge core_clk);
    sqi <= 0;
    wr(32'h1580, 32'h0764);
    pulse(5'h2);
    settle(3);
    chk(lfail, 6);
    rd32(32'h1584);
    chk(rd, 32'h6);
    chk(irq, 1);
    wr(32'h2000, 32'h1);
    settle(1);
    chk(irq, 0);
    // With every failure scenario masked off, neither events nor a quality drop may count.
    wr(32'h1580, 32'h0004);
    for (int i = 0; i < 5; i++) pulse(5'(1 << i));
    @(posedge core_clk);
    sqi <= 7;
    settle(3);
    chk(lfail, 6);
    summarize();
  end
endmodule
`default_nettype wire
